// file: logic/multidrop_poll_status_regs.sv
// Polling master status and control registers for a multi-drop serial line.
// Assumes an APB master on the same clock and link logic that answers each
// exchange request with a done pulse, all on sys_clk_in.
//
// Functional notes
// - Enrolment bit n is station n; bit0 zero.
// - Load enrolment from stored configuration at start.
// - Software adds/removes stations; scan follows live.
// - Presence shows online enrolled stations only.
// - Online only while exchanges complete normally; the code keeps a station online through its first failed exchange.
// - Keep poll period in 10 ms units.
// - Fault bit stands exactly one scan period.
// - Master and slaves share one baud rate.
// - Probe enrolled stations in ascending order.
// - Probe answer waits at most 30 ms.
// - Probe one offline station per scan cycle.
// - First miss retried next cycle; second offline.
`timescale 1ns/100ps
`include "poll_defs.svh"

module multidrop_poll_status_regs #(
    parameter int MS_CYCLES = `MS_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cfg_load_in,
    input wire logic [15:0] cfg_mask_in,
    input poll_pkg::xfer_rsp_s xfer_rsp_in,
    output poll_pkg::xfer_cmd_s xfer_cmd_out,
    output logic [15:0] baud_div_out,
    output logic irq_out
);

    // ------------------------------------------------------------------------
    // Millisecond enable
    // ------------------------------------------------------------------------
    logic ms_tick;

    poll_tick_divider #(
        .DIV(MS_CYCLES)
    ) u_ms_tick (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .tick_out(ms_tick)
    );

    // ------------------------------------------------------------------------
    // Probe candidate search
    // ------------------------------------------------------------------------
    // Returns found flag and the first candidate station after ptr, wrapping.
    function automatic logic [4:0] find_probe(input logic [15:0] cand, input logic [3:0] ptr);
        logic [4:0] r;
        logic [4:0] s;
        r = 5'h00;
        for (int k = 15; k >= 1; k--) begin
            s = 5'(ptr) + 5'(k);
            if (s > 5'h0F) begin
                s = s - 5'h0F;
            end
            if (cand[s[3:0]]) begin
                r = {1'b1, s[3:0]};
            end
        end
        return r;
    endfunction : find_probe

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    poll_pkg::poll_state_s q;
    poll_pkg::poll_state_s d;

    logic [`IRQ_W-1:0] ev;
    logic [`IRQ_W-1:0] w1c;
    logic [31:0] rdata;
    logic mapped;
    logic wr_done;
    logic scan_end;
    logic [4:0] cand;
    logic [15:0] presence;
    logic [3:0] cur;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        d = q;
        ev = '0;
        w1c = '0;
        rdata = 32'h00000000;
        mapped = 1'b0;
        wr_done = 1'b0;
        scan_end = 1'b0;
        cur = q.xfer.station;
        presence = q.online & q.enrol & 16'hFFFE;
        cand = find_probe(q.enrol & ~q.online & 16'hFFFE, q.probe_ptr);
        d.xfer.req = 1'b0;
        d.xfer.abort = 1'b0;

        // --------------------------------------------------------------------
        // Period measurement in 10 ms units.
        // --------------------------------------------------------------------
        if (ms_tick) begin
            if (q.ms_in == `PERIOD_UNIT_MS - 4'h1) begin
                d.ms_in = 4'h0;
                if (q.units != 16'hFFFF) begin
                    d.units = q.units + 16'h0001;
                end
            end else begin
                d.ms_in = q.ms_in + 4'h1;
            end
        end

        // --------------------------------------------------------------------
        // Scan engine.
        // --------------------------------------------------------------------
        case (q.st)
            poll_pkg::ST_SELECT: begin
                if (!q.probe_phase) begin
                    if (q.enrol[q.idx] && q.online[q.idx]) begin
                        d.xfer.station = q.idx;
                        d.xfer.probe = 1'b0;
                        d.st = poll_pkg::ST_ISSUE;
                    end else if (q.idx == `STATION_LAST) begin
                        d.probe_phase = 1'b1;
                    end else begin
                        d.idx = q.idx + 4'h1;
                    end
                end else begin
                    if (cand[4]) begin
                        d.xfer.station = cand[3:0];
                        d.xfer.probe = 1'b1;
                        d.probe_ptr = cand[3:0];
                        d.st = poll_pkg::ST_ISSUE;
                    end else begin
                        scan_end = 1'b1;
                    end
                end
            end
            poll_pkg::ST_ISSUE: begin
                d.xfer.req = 1'b1;
                d.wait_ms = 5'h00;
                d.st = poll_pkg::ST_WAIT;
            end
            poll_pkg::ST_WAIT: begin
                if (ms_tick) begin
                    d.wait_ms = q.wait_ms + 5'h01;
                end
                if (xfer_rsp_in.done && xfer_rsp_in.ok) begin
                    d.online[cur] = 1'b1;
                    d.miss[cur] = 1'b0;
                    if (q.xfer.probe) begin
                        ev[`IRQ_BIT_ONLINE] = 1'b1;
                    end
                    d.st = poll_pkg::ST_CLOSE;
                end else if (xfer_rsp_in.done ||
                             (ms_tick && q.wait_ms == `PROBE_TIMEOUT_MS - 5'h01)) begin
                    d.xfer.abort = !xfer_rsp_in.done;
                    d.fault_acc[cur] = 1'b1;
                    ev[`IRQ_BIT_FAULT] = 1'b1;
                    if (!q.xfer.probe) begin
                        if (q.miss[cur]) begin
                            d.online[cur] = 1'b0;
                            d.miss[cur] = 1'b0;
                            ev[`IRQ_BIT_OFFLINE] = 1'b1;
                        end else begin
                            d.miss[cur] = 1'b1;
                        end
                    end
                    d.st = poll_pkg::ST_CLOSE;
                end
            end
            poll_pkg::ST_CLOSE: begin
                d.st = poll_pkg::ST_SELECT;
                if (q.xfer.probe) begin
                    scan_end = 1'b1;
                end else if (q.idx == `STATION_LAST) begin
                    d.probe_phase = 1'b1;
                end else begin
                    d.idx = q.idx + 4'h1;
                end
            end
            default: begin
                d.st = poll_pkg::ST_SELECT;
            end
        endcase

        // --------------------------------------------------------------------
        // End of one scan: publish faults and the measured period.
        // --------------------------------------------------------------------
        if (scan_end) begin
            d.fault = q.fault_acc & 16'hFFFE;
            d.fault_acc = 16'h0000;
            d.interval = q.units;
            d.units = 16'h0000;
            d.ms_in = 4'h0;
            d.idx = `STATION_FIRST;
            d.probe_phase = 1'b0;
            ev[`IRQ_BIT_SCAN] = 1'b1;
        end

        // --------------------------------------------------------------------
        // APB read mux.
        // --------------------------------------------------------------------
        case (paddr)
            `OFF_ENROL: begin
                rdata = {16'h0000, q.enrol & 16'hFFFE};
                mapped = 1'b1;
            end
            `OFF_PRESENCE: begin
                rdata = {16'h0000, presence};
                mapped = 1'b1;
            end
            `OFF_INTERVAL: begin
                rdata = {16'h0000, q.interval};
                mapped = 1'b1;
            end
            `OFF_FAULT: begin
                rdata = {16'h0000, q.fault};
                mapped = 1'b1;
            end
            `OFF_BAUD: begin
                rdata = {16'h0000, q.baud};
                mapped = 1'b1;
            end
            `OFF_IRQ_STAT: begin
                rdata = {28'h0000000, q.irq_stat};
                mapped = 1'b1;
            end
            `OFF_IRQ_MASK: begin
                rdata = {28'h0000000, q.irq_mask};
                mapped = 1'b1;
            end
            default: begin
                rdata = 32'h00000000;
                mapped = 1'b0;
            end
        endcase

        // --------------------------------------------------------------------
        // APB handshake: one wait state, write takes effect at completion.
        // --------------------------------------------------------------------
        d.pready = 1'b0;
        if (psel && penable && !q.pready) begin
            d.pready = 1'b1;
            d.pslverr = !mapped;
            d.prdata = pwrite ? 32'h00000000 : rdata;
        end
        if (psel && penable && q.pready) begin
            d.pslverr = 1'b0;
            wr_done = pwrite && mapped;
        end
        if (wr_done) begin
            case (paddr)
                `OFF_ENROL: begin
                    d.enrol = pwdata[15:0] & 16'hFFFE;
                end
                `OFF_BAUD: begin
                    d.baud = pwdata[15:0];
                end
                `OFF_IRQ_STAT: begin
                    w1c = pwdata[`IRQ_W-1:0];
                end
                `OFF_IRQ_MASK: begin
                    d.irq_mask = pwdata[`IRQ_W-1:0];
                end
                `OFF_PRESENCE: begin
                    w1c = '0;
                end
                `OFF_INTERVAL: begin
                    w1c = '0;
                end
                `OFF_FAULT: begin
                    w1c = '0;
                end
                default: begin
                    w1c = '0;
                end
            endcase
        end

        // --------------------------------------------------------------------
        // Stored connection configuration reload, also once after reset.
        // --------------------------------------------------------------------
        if (q.load_pend || cfg_load_in) begin
            d.enrol = cfg_mask_in & 16'hFFFE;
            d.online = 16'h0000;
            d.miss = 16'h0000;
            d.fault_acc = 16'h0000;
            d.probe_ptr = `STATION_NONE;
            d.idx = `STATION_FIRST;
            d.probe_phase = 1'b0;
            d.load_pend = 1'b0;
        end

        // --------------------------------------------------------------------
        // Removed stations drop out of the online set at once.
        // --------------------------------------------------------------------
        d.online = d.online & d.enrol;
        d.miss = d.miss & d.enrol;

        // --------------------------------------------------------------------
        // Sticky status, set wins over clear.
        // --------------------------------------------------------------------
        d.irq_stat = (q.irq_stat & ~w1c) | ev;
        d.irq = |(d.irq_stat & d.irq_mask);
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            q <= '0;
            q.idx <= `STATION_FIRST;
            q.load_pend <= 1'b1;
            q.baud <= `BAUD_DIV_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign xfer_cmd_out = q.xfer;
    assign baud_div_out = q.baud;
    assign irq_out = q.irq;

endmodule : multidrop_poll_status_regs

// file: logic/poll_defs.svh
// Named offsets, reset values and timing figures of the polling status registers.
// Assumes inclusion by bare name from the package and the top module.
`ifndef POLL_DEFS_SVH
`define POLL_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFF_ENROL 8'h00
`define OFF_PRESENCE 8'h04
`define OFF_INTERVAL 8'h08
`define OFF_FAULT 8'h0C
`define OFF_BAUD 8'h10
`define OFF_IRQ_STAT 8'h14
`define OFF_IRQ_MASK 8'h18

// ----------------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------------
`define BAUD_DIV_RST 16'h00D9
`define STATION_FIRST 4'h1
`define STATION_LAST 4'hF
`define STATION_NONE 4'h0
`define IRQ_BIT_ONLINE 0
`define IRQ_BIT_OFFLINE 1
`define IRQ_BIT_FAULT 2
`define IRQ_BIT_SCAN 3
`define IRQ_W 4

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_HZ 25000000
`define MS_PER_S 1000
`define MS_CYCLES (`CLK_HZ / `MS_PER_S)
`define PROBE_TIMEOUT_MS 5'h1E
`define PERIOD_UNIT_MS 4'hA

`endif

// file: logic/poll_pkg.sv
// Types shared by the polling status register block and its tick divider.
// Assumes the constants header is on the include path.
`include "poll_defs.svh"

package poll_pkg;

    // ------------------------------------------------------------------------
    // Scan engine states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_SELECT = 2'h0,
        ST_ISSUE = 2'h1,
        ST_WAIT = 2'h3,
        ST_CLOSE = 2'h2
    } scan_state_e;

    // ------------------------------------------------------------------------
    // Link exchange carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic req;
        logic probe;
        logic abort;
        logic [3:0] station;
    } xfer_cmd_s;

    typedef struct packed {
        logic done;
        logic ok;
    } xfer_rsp_s;

    // ------------------------------------------------------------------------
    // Module state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [19:0] count;
        logic tick;
    } tick_state_s;

    typedef struct packed {
        scan_state_e st;
        logic [3:0] idx;
        logic probe_phase;
        logic [3:0] probe_ptr;
        logic [15:0] enrol;
        logic [15:0] online;
        logic [15:0] miss;
        logic [15:0] fault_acc;
        logic [15:0] fault;
        logic [15:0] interval;
        logic [15:0] units;
        logic [3:0] ms_in;
        logic [4:0] wait_ms;
        logic load_pend;
        logic [15:0] baud;
        logic [`IRQ_W-1:0] irq_stat;
        logic [`IRQ_W-1:0] irq_mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        xfer_cmd_s xfer;
    } poll_state_s;

endpackage : poll_pkg

// file: logic/poll_tick_divider.sv
// One-cycle enable pulse every DIV clock cycles.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/100ps

module poll_tick_divider #(
    parameter int DIV = 25000
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    output logic tick_out
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    poll_pkg::tick_state_s q;
    poll_pkg::tick_state_s d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.count == 20'(DIV - 1)) begin
            d.count = 20'h00000;
            d.tick = 1'b1;
        end else begin
            d.count = q.count + 20'h00001;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_out = q.tick;

endmodule : poll_tick_divider

// file: testbench/multidrop_poll_status_regs_tb.sv
// Self-checking bench for the polling status register block.
// Assumes the checker and the link model are compiled before it.
`timescale 1ns/100ps

module multidrop_poll_status_regs_tb;
    // ------------------------------------------------------------------------
    // Stimulus and checking
    // ------------------------------------------------------------------------
    logic sys_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cfg_load_in = 1'b0;
    logic [15:0] cfg_mask_in = 16'h000F;
    logic [15:0] present = 16'h000A;
    logic [15:0] nak = 16'h0000;
    logic [15:0] baud_div;
    logic irq;
    poll_pkg::xfer_cmd_s cmd;
    poll_pkg::xfer_rsp_s rsp;
    logic [32:0] expq[$];
    int n_errors = 0;
    int total_checks = 0;
    int seed = 59;

    always #20 sys_clk_in = ~sys_clk_in;

    multidrop_poll_status_regs #(.MS_CYCLES(10)) DUT (.sys_clk_in(sys_clk_in),
        .srst_in(srst_in), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cfg_load_in(cfg_load_in), .cfg_mask_in(cfg_mask_in), .xfer_rsp_in(rsp),
        .xfer_cmd_out(cmd), .baud_div_out(baud_div), .irq_out(irq));

    poll_link_model link (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .cmd_in(cmd),
        .baud_div_in(baud_div), .present_in(present), .nak_in(nak), .delay_in(8'h03),
        .rsp_out(rsp));

    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        n = 0;
        if (!wr) expq.push_back(e);
        @(posedge sys_clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_errors++;
            finish_test();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000, {1'b0, e});
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h000000000);
    endtask : wr

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : idle

    always @(posedge sys_clk_in) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check("read", {pslverr, prdata}, expq.pop_front());
        end
    end

    initial begin
        idle(100000);
        n_errors++;
        finish_test();
    end

    initial begin
        idle(4);
        srst_in <= 1'b0;
        idle(2);
        rd(8'h00, 32'h0000000E);
        rd(8'h10, 32'h000000D9);
        apb(1'b0, 8'h40, 32'h00000000, {1'b1, 32'h00000000});
        wr(8'h04, $random(seed));
        idle(2000);
        rd(8'h04, 32'h0000000A);
        $display("test discovery done");
        present <= 16'h001A;
        wr(8'h00, ($random(seed) & 32'hFFFF0000) | 32'h00000013);
        rd(8'h00, 32'h00000012);
        idle(1000);
        rd(8'h04, 32'h00000012);
        $display("test enrolment change done");
        nak <= 16'h0002;
        idle(800);
        rd(8'h04, 32'h00000010);
        rd(8'h0C, 32'h00000002);
        wr(8'h18, 32'h00000000);
        idle(2);
        check("irq masked", {32'h00000000, irq}, 33'h000000000);
        wr(8'h18, 32'h00000002);
        idle(2);
        check("irq offline", {32'h00000000, irq}, 33'h000000001);
        wr(8'h14, 32'h00000002);
        idle(2);
        check("irq cleared", {32'h00000000, irq}, 33'h000000000);
        $display("test failure handling done");
        nak <= 16'h0000;
        idle(1000);
        rd(8'h04, 32'h00000012);
        wr(8'h0C, $random(seed));
        rd(8'h0C, 32'h00000000);
        cfg_mask_in <= 16'h0007;
        cfg_load_in <= 1'b1;
        idle(1);
        cfg_load_in <= 1'b0;
        rd(8'h00, 32'h00000006);
        idle(1000);
        rd(8'h08, 32'h00000003);
        $display("test recovery and reload done");
        wr(8'h10, 32'h00000055);
        rd(8'h10, 32'h00000055);
        idle(2000);
        rd(8'h04, 32'h00000000);
        $display("test baud mismatch done");
        finish_test();
    end
endmodule : multidrop_poll_status_regs_tb

// file: testbench/poll_link_model.sv
// Behavioural model of the slave stations on the shared line.
// Assumes the master's exchange command carrier on the same clock.
`timescale 1ns/100ps

module poll_link_model #(
    parameter logic [15:0] BAUD = 16'h00D9
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input poll_pkg::xfer_cmd_s cmd_in,
    input wire logic [15:0] baud_div_in,
    input wire logic [15:0] present_in,
    input wire logic [15:0] nak_in,
    input wire logic [7:0] delay_in,
    output poll_pkg::xfer_rsp_s rsp_out
);
    // ------------------------------------------------------------------------
    // Answer engine
    // ------------------------------------------------------------------------
    logic busy;
    logic [7:0] cnt;
    logic [3:0] stn;
    logic fire;

    assign fire = busy && cnt == 8'h00 && !cmd_in.req && !cmd_in.abort;

    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            busy <= 1'b0;
            rsp_out <= '0;
        end else begin
            rsp_out.done <= fire;
            rsp_out.ok <= fire ? !nak_in[stn] : ~rsp_out.ok;
            if (cmd_in.req) begin
                busy <= present_in[cmd_in.station] && baud_div_in == BAUD;
                cnt <= delay_in;
                stn <= cmd_in.station;
            end else if (cmd_in.abort) begin
                busy <= 1'b0;
            end else if (fire) begin
                busy <= 1'b0;
            end else if (busy) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule : poll_link_model

// file: testbench/poll_regs_asserts.sv
// Checker for the polling status register block, seeing only its ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps

module poll_regs_asserts #(
    parameter int MS_CYCLES = 10
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cfg_load_in,
    input wire logic [15:0] cfg_mask_in,
    input poll_pkg::xfer_rsp_s xfer_rsp_in,
    input poll_pkg::xfer_cmd_s xfer_cmd_out,
    input wire logic [15:0] baud_div_out,
    input wire logic irq_out
);
    // ------------------------------------------------------------------------
    // Exchange wait counter
    // ------------------------------------------------------------------------
    localparam int LO = 29 * MS_CYCLES - 4;
    localparam int HI = 30 * MS_CYCLES + 4;
    logic out_q;
    logic [31:0] wcnt_q;

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            out_q <= 1'b0;
        end else if (xfer_cmd_out.req) begin
            out_q <= 1'b1;
        end else if (xfer_rsp_in.done || xfer_cmd_out.abort) begin
            out_q <= 1'b0;
        end
        wcnt_q <= xfer_cmd_out.req ? 32'h00000000 : wcnt_q + 32'h00000001;
    end

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    ready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("ready not one cycle after access");
    err_unmapped_a: assert property (pslverr |-> pready && (paddr > 8'h18 || paddr[1:0] != 2'h0))
        else $error("error on mapped address");
    enrol_bit0_a: assert property (pready && !pwrite && paddr == 8'h00 |-> !prdata[0])
        else $error("enrolment bit 0 set");
    req_pulse_a: assert property (xfer_cmd_out.req |=> !xfer_cmd_out.req)
        else $error("request longer than one cycle");
    single_out_a: assert property (out_q && !xfer_rsp_in.done |-> !xfer_cmd_out.req)
        else $error("second exchange while one is open");
    req_gap_a: assert property (xfer_rsp_in.done || xfer_cmd_out.abort |=> !xfer_cmd_out.req)
        else $error("request too soon after end");
    station_ok_a: assert property (xfer_cmd_out.req |-> xfer_cmd_out.station != 4'h0)
        else $error("request to station 0");
    abort_early_a: assert property (xfer_cmd_out.abort |-> out_q && wcnt_q >= LO)
        else $error("abort too early");
    wait_bound_a: assert property (out_q |-> wcnt_q <= HI)
        else $error("exchange open too long");
    baud_reset_a: assert property (disable iff (1'b0) srst_in |=> baud_div_out == 16'h00D9)
        else $error("baud divider reset value wrong");
endmodule : poll_regs_asserts

bind multidrop_poll_status_regs poll_regs_asserts #(.MS_CYCLES(MS_CYCLES)) chk (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg_load_in(cfg_load_in), .cfg_mask_in(cfg_mask_in),
    .xfer_rsp_in(xfer_rsp_in), .xfer_cmd_out(xfer_cmd_out), .baud_div_out(baud_div_out),
    .irq_out(irq_out));
